// >>> rtl/pofw_defs.svh
`ifndef POFW_DEFS_SVH
`define POFW_DEFS_SVH
`define POFW_CMD_OPERATION 8'h01
`define POFW_CMD_ON_OFF_SETUP 8'h02
`define POFW_CMD_CLEAR_FAULTS 8'h03
`define POFW_CMD_WRITE_LOCK 8'h10
`define POFW_CMD_STORE_ALL 8'h11
`define POFW_CMD_RESTORE_ALL 8'h12
`define POFW_CMD_VOUT 8'h21
`define POFW_SETUP_RST 8'h16
`define POFW_LOCK_RST 8'h00
`define POFW_BIT_PU 4
`define POFW_BIT_CMD 3
`define POFW_BIT_CPR 2
`define POFW_BIT_POL 1
`define POFW_BIT_CPA 0
`define POFW_BIT_ON 7
`define POFW_BIT_SOFT 6
`endif

// >>> rtl/pofw_pkg.sv
package pofw_pkg;
	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic [7:0] data;
		logic has_data;
	} pofw_cmd_t;
	typedef struct packed {
		logic run;
		logic hard_off;
		logic ls_on;
		logic alert;
		logic cml;
		logic ov_flag;
		logic fault_flag;
	} pofw_stat_t;
	typedef enum logic [1:0] {POFW_OFF, POFW_RUN, POFW_LATCH} pofw_state_t;
endpackage

// >>> rtl/pofw_ctrl.sv
`timescale 1ns/1ps
`include "pofw_defs.svh"
module pofw_ctrl (
	input wire logic i_clk, // 250 MHz
	input wire logic i_srst, // sync reset, also power-up reload
	input wire pofw_pkg::pofw_cmd_t i_cmd, // decoded host command/write
	input wire logic [7:0] i_rd_code, // read command code
	input wire logic [7:0] i_nvm_setup, // stored setup value
	input wire logic [7:0] i_nvm_lock, // stored lock value
	input wire logic [7:0] i_nvm_oper, // stored operation value
	input wire logic i_enable_pin, // external enable pin
	input wire logic i_vin_ok, // input above lockout
	input wire logic i_fault, // fault condition present
	input wire logic i_fault_latch, // fault response is latch-off
	input wire logic i_ov_fault, // overvoltage condition
	input wire logic i_below_uv, // output below undervoltage limit
	input wire logic i_ov_release_select, // release switch at uv
	output logic [7:0] o_rd_data, // read data
	output logic o_store_req, // pulse: store setup and lock
	output logic [7:0] o_store_setup, // setup value to store
	output logic [7:0] o_store_lock, // lock value to store
	output logic o_vout_we, // pulse: vout write accepted
	output logic o_other_we, // pulse: other write accepted
	output pofw_pkg::pofw_stat_t o_stat // control and status
);
	import pofw_pkg::*;

	// ****************************************
	// lock decode
	// ****************************************
	function automatic logic allowed(input logic [7:0] lock, input logic [7:0] code);
		logic ok;
		ok = 1'b1;
		case (lock[7:5])
			3'b100: ok = (code == `POFW_CMD_WRITE_LOCK);
			3'b010: ok = (code == `POFW_CMD_WRITE_LOCK) || (code == `POFW_CMD_OPERATION);
			3'b001: ok = (code == `POFW_CMD_WRITE_LOCK) || (code == `POFW_CMD_OPERATION) ||
				(code == `POFW_CMD_ON_OFF_SETUP) || (code == `POFW_CMD_VOUT);
			default: ok = 1'b1;
		endcase
		return ok;
	endfunction

	function automatic logic multi(input logic [7:0] lock);
		return (lock[7] & lock[6]) | (lock[7] & lock[5]) | (lock[6] & lock[5]);
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [7:0] setup_reg, setup_next;
	logic [7:0] lock_reg, lock_next;
	logic [7:0] oper_reg, oper_next;
	logic pol_reg, pol_next;
	logic [7:0] rd_reg, rd_next;
	logic store_reg, store_next;
	logic vout_we_reg, vout_we_next;
	logic other_we_reg, other_we_next;
	logic ov_flag_reg, ov_flag_next;
	logic ov_armed_reg, ov_armed_next;
	logic fault_flag_reg, fault_flag_next;
	logic cml_reg, cml_next;
	logic alert_reg, alert_next;
	logic ls_reg, ls_next;
	logic hard_reg, hard_next;
	pofw_state_t state_reg, state_next;
	logic boot_reg;

	logic pin_on, op_on, want_on, wr_ok, clr;

	always_comb begin
		wr_ok = i_cmd.valid && allowed(lock_reg, i_cmd.code);
		clr = wr_ok && (i_cmd.code == `POFW_CMD_CLEAR_FAULTS);
		pin_on = pol_reg ? i_enable_pin : ~i_enable_pin;
		op_on = oper_reg[`POFW_BIT_ON] && i_vin_ok && !i_fault;
		if (!setup_reg[`POFW_BIT_PU]) begin
			want_on = i_vin_ok;
		end else begin
			want_on = i_vin_ok && setup_reg[`POFW_BIT_PU]
				&& (!setup_reg[`POFW_BIT_CPR] || pin_on)
				&& (!setup_reg[`POFW_BIT_CMD] || op_on)
				&& (setup_reg[`POFW_BIT_CPR] || setup_reg[`POFW_BIT_CMD]);
		end

		setup_next = setup_reg;
		lock_next = lock_reg;
		oper_next = oper_reg;
		pol_next = pol_reg;
		store_next = 1'b0;
		vout_we_next = 1'b0;
		other_we_next = 1'b0;
		if (wr_ok && i_cmd.has_data) begin
			case (i_cmd.code)
				`POFW_CMD_ON_OFF_SETUP: setup_next = {3'b000, i_cmd.data[4:0]};
				`POFW_CMD_WRITE_LOCK: lock_next = {i_cmd.data[7:5], 5'b00000};
				`POFW_CMD_OPERATION: begin
					if (!(i_cmd.data[7] & i_cmd.data[6])) begin
						oper_next = {i_cmd.data[7:6], 6'b000000};
					end
				end
				`POFW_CMD_VOUT: vout_we_next = 1'b1;
				default: other_we_next = 1'b1;
			endcase
		end
		if (i_cmd.valid && !i_cmd.has_data && i_cmd.code == `POFW_CMD_STORE_ALL) begin
			store_next = 1'b1;
		end
		if (i_cmd.valid && !i_cmd.has_data && i_cmd.code == `POFW_CMD_RESTORE_ALL) begin
			if (allowed(lock_reg, `POFW_CMD_ON_OFF_SETUP)) begin
				setup_next = {3'b000, i_nvm_setup[4:0]};
			end
			if (allowed(lock_reg, `POFW_CMD_OPERATION)) begin
				oper_next = {i_nvm_oper[7:6], 6'b000000};
			end
			lock_next = {i_nvm_lock[7:5], 5'b00000};
		end

		rd_next = 8'h00;
		case (i_rd_code)
			`POFW_CMD_ON_OFF_SETUP: rd_next = setup_reg;
			`POFW_CMD_WRITE_LOCK: rd_next = lock_reg;
			`POFW_CMD_OPERATION: rd_next = oper_reg;
			default: rd_next = 8'h00;
		endcase
	end

	// ****************************************
	// faults and run state
	// ****************************************
	always_comb begin
		state_next = state_reg;
		hard_next = hard_reg;
		ls_next = ls_reg;
		fault_flag_next = fault_flag_reg;
		ov_flag_next = ov_flag_reg;
		ov_armed_next = ov_armed_reg;
		cml_next = cml_reg;
		if (clr) begin
			fault_flag_next = 1'b0;
			cml_next = 1'b0;
			if (ov_armed_reg) begin
				ov_flag_next = 1'b0;
			end
			ov_armed_next = ov_flag_reg;
			ls_next = 1'b0;
		end
		if (i_fault) begin
			fault_flag_next = 1'b1;
		end
		if (i_ov_fault) begin
			ov_flag_next = 1'b1;
			ov_armed_next = 1'b0;
		end
		if (i_cmd.valid && multi(i_cmd.code == `POFW_CMD_WRITE_LOCK ? lock_next : 8'h00)) begin
			cml_next = 1'b1;
		end
		if (i_cmd.valid && i_cmd.has_data && i_cmd.code == `POFW_CMD_OPERATION &&
			i_cmd.data[7] && i_cmd.data[6]) begin
			cml_next = 1'b1;
		end
		if (i_ov_fault && i_fault_latch) begin
			ls_next = 1'b1;
		end else if (ls_reg && i_ov_release_select && i_below_uv) begin
			ls_next = 1'b0;
		end
		case (state_reg)
			POFW_OFF: begin
				if (want_on && !i_fault) begin
					state_next = POFW_RUN;
				end
			end
			POFW_RUN: begin
				if (i_fault && i_fault_latch) begin
					state_next = POFW_LATCH;
					hard_next = 1'b1;
				end else if (!want_on || i_fault) begin
					state_next = POFW_OFF;
					if (setup_reg[`POFW_BIT_CPR] && !pin_on) begin
						hard_next = setup_reg[`POFW_BIT_CPA];
					end else begin
						hard_next = !oper_reg[`POFW_BIT_SOFT];
					end
				end
			end
			POFW_LATCH: state_next = POFW_LATCH;
			default: state_next = POFW_OFF;
		endcase
		alert_next = fault_flag_next | ov_flag_next | cml_next;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			setup_reg <= `POFW_SETUP_RST;
			lock_reg <= `POFW_LOCK_RST;
			oper_reg <= 8'h00;
			pol_reg <= 1'b1;
			boot_reg <= 1'b1;
			rd_reg <= 8'h00;
			store_reg <= 1'b0;
			vout_we_reg <= 1'b0;
			other_we_reg <= 1'b0;
			ov_flag_reg <= 1'b0;
			ov_armed_reg <= 1'b0;
			fault_flag_reg <= 1'b0;
			cml_reg <= 1'b0;
			alert_reg <= 1'b0;
			ls_reg <= 1'b0;
			hard_reg <= 1'b0;
			state_reg <= POFW_OFF;
		end else if (boot_reg) begin
			// reload stored settings once after reset release
			setup_reg <= {3'b000, i_nvm_setup[4:0]};
			pol_reg <= i_nvm_setup[`POFW_BIT_POL];
			lock_reg <= {i_nvm_lock[7:5], 5'b00000};
			oper_reg <= {i_nvm_oper[7:6], 6'b000000};
			boot_reg <= 1'b0;
		end else begin
			setup_reg <= setup_next;
			lock_reg <= lock_next;
			oper_reg <= oper_next;
			pol_reg <= pol_next;
			rd_reg <= rd_next;
			store_reg <= store_next;
			vout_we_reg <= vout_we_next;
			other_we_reg <= other_we_next;
			ov_flag_reg <= ov_flag_next;
			ov_armed_reg <= ov_armed_next;
			fault_flag_reg <= fault_flag_next;
			cml_reg <= cml_next;
			alert_reg <= alert_next;
			ls_reg <= ls_next;
			hard_reg <= hard_next;
			state_reg <= state_next;
		end
	end

	always_ff @(posedge i_clk) begin
		o_rd_data <= rd_reg;
		o_store_req <= store_reg;
		o_store_setup <= setup_reg;
		o_store_lock <= lock_reg;
		o_vout_we <= vout_we_reg;
		o_other_we <= other_we_reg;
		o_stat <= '{run: (state_reg == POFW_RUN), hard_off: hard_reg, ls_on: ls_reg,
			alert: alert_reg, cml: cml_reg, ov_flag: ov_flag_reg, fault_flag: fault_flag_reg};
	end
endmodule

// >>> tb/pofw_sva.sv
`timescale 1ns/1ps
module pofw_sva (
	input wire logic i_clk, // clock
	input wire logic i_srst, // sync reset
	input wire pofw_pkg::pofw_cmd_t i_cmd, // host command
	input wire logic [7:0] i_rd_code, // read code
	input wire logic i_vin_ok, // input ok
	input wire logic i_fault, // fault present
	input wire logic [7:0] o_rd_data, // read data
	input wire logic o_store_req, // store pulse
	input wire logic o_vout_we, // vout write pulse
	input wire pofw_pkg::pofw_stat_t o_stat // status
);
	import pofw_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	property p_store; i_cmd.valid && i_cmd.code == 8'h11 |-> ##2 o_store_req; endproperty
	a_store: assert property (p_store) else $error("store pulse missing");
	property p_store_src; o_store_req |-> $past(i_cmd.code, 2) == 8'h11; endproperty
	a_store_src: assert property (p_store_src) else $error("stray store pulse");
	property p_vout; o_vout_we |-> $past(i_cmd.code, 2) == 8'h21; endproperty
	a_vout: assert property (p_vout) else $error("stray vout write");
	property p_clear;
		i_cmd.valid && i_cmd.code == 8'h03 && !i_fault && !$past(i_fault) ##1 !i_fault
			|=> !o_stat.fault_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("fault flag not cleared");
	property p_refault; i_fault [*3] |-> o_stat.fault_flag; endproperty
	a_refault: assert property (p_refault) else $error("fault flag not set");
	property p_rd_zero; (i_rd_code == 8'h7f) [*3] |-> o_rd_data == 8'h00; endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("unknown code read not zero");
	property p_vin; !i_vin_ok [*3] |-> !o_stat.run; endproperty
	a_vin: assert property (p_vin) else $error("running without input");
	property p_lock_bad;
		i_cmd.valid && i_cmd.code == 8'h10 && $countones(i_cmd.data[7:5]) > 1 |-> ##2 o_stat.cml;
	endproperty
	a_lock_bad: assert property (p_lock_bad) else $error("bad lock not flagged");
endmodule

// >>> tb/pofw_host.sv
`timescale 1ns/1ps
module pofw_host #(
	parameter int GAP = 4
) (
	input wire logic i_clk, // clock
	output pofw_pkg::pofw_cmd_t o_cmd // command to device
);
	import pofw_pkg::*;
	initial o_cmd = '0;
	task automatic send(input logic [7:0] code, input logic [7:0] data, input logic hd);
		@(negedge i_clk);
		o_cmd = '{1'b1, code, data, hd};
		@(negedge i_clk);
		o_cmd = '{1'b0, ~code, ~data, 1'b0};
	endtask
	task automatic clear_twice;
		repeat (GAP) @(negedge i_clk); // let shutdown settle first
		send(8'h03, 8'h00, 1'b0);
		send(8'h03, 8'h00, 1'b0); // second clear for overvoltage
	endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
	import pofw_pkg::*;
	logic i_clk = 0;
	logic i_srst = 1;
	logic [7:0] rd_code = 8'h7f;
	logic [7:0] nvm_set = 8'h16;
	logic pin = 1;
	logic vin = 1;
	logic flt = 0;
	logic flat = 0;
	logic ov = 0;
	logic buv = 0;
	logic ovrs = 0;
	pofw_cmd_t cmd;
	logic [7:0] rd_data;
	logic [7:0] st_setup;
	logic store;
	logic vwe;
	pofw_stat_t stat;
	int bad_count = 0;
	int tests_run = 0;
	always #2 i_clk = ~i_clk;
	pofw_host #(.GAP(4)) i_pofw_host(.i_clk(i_clk), .o_cmd(cmd));
	pofw_ctrl i_pofw_ctrl(.i_clk(i_clk), .i_srst(i_srst), .i_cmd(cmd), .i_rd_code(rd_code),
		.i_nvm_setup(nvm_set), .i_nvm_lock(8'h00), .i_nvm_oper(8'h00), .i_enable_pin(pin),
		.i_vin_ok(vin), .i_fault(flt), .i_fault_latch(flat), .i_ov_fault(ov),
		.i_below_uv(buv), .i_ov_release_select(ovrs), .o_rd_data(rd_data),
		.o_store_req(store), .o_store_setup(st_setup), .o_store_lock(), .o_vout_we(vwe),
		.o_other_we(), .o_stat(stat));
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wt;
		repeat (4) @(negedge i_clk);
	endtask
	task automatic rd(input logic [7:0] code, input logic [7:0] exp);
		@(negedge i_clk);
		rd_code = code;
		repeat (3) @(negedge i_clk);
		chk("read", exp, rd_data);
		rd_code = 8'h7f;
	endtask
	task automatic wr(input logic [7:0] code, input logic [7:0] data);
		i_pofw_host.send(code, data, 1'b1);
	endtask
	task automatic clr;
		i_pofw_host.send(8'h03, 8'h00, 1'b0);
		wt;
	endtask
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge i_clk);
		bad_count++;
		complete_run;
	end
	initial begin
		repeat (12) @(negedge i_clk);
		i_srst = 1'b0;
		repeat (3) @(negedge i_clk);
		rd(8'h02, 8'h16);
		rd(8'h10, 8'h00);
		rd(8'h01, 8'h00);
		chk("run", 8'h01, {7'h0, stat.run});
		pin = 1'b0;
		wt;
		chk("run", 8'h00, {7'h0, stat.run});
		wr(8'h02, 8'hff);
		rd(8'h02, 8'h1f);
		wr(8'h02, 8'h14);
		pin = 1'b1;
		wt;
		chk("run", 8'h01, {7'h0, stat.run});
		wr(8'h02, 8'h00);
		pin = 1'b0;
		wt;
		chk("run", 8'h01, {7'h0, stat.run});
		wr(8'h02, 8'h18);
		wr(8'h01, 8'h80);
		wt;
		chk("run", 8'h01, {7'h0, stat.run});
		vin = 1'b0;
		wt;
		chk("run", 8'h00, {7'h0, stat.run});
		vin = 1'b1;
		wr(8'h01, 8'h00);
		wt;
		chk("run", 8'h00, {7'h0, stat.run});
		i_pofw_host.send(8'h11, 8'h00, 1'b0);
		chk("stored", 8'h18, st_setup);
		wr(8'h10, 8'h20);
		wr(8'h21, 8'h55);
		wr(8'h02, 8'h04);
		rd(8'h02, 8'h04);
		wr(8'h10, 8'h40);
		wr(8'h02, 8'h00);
		rd(8'h02, 8'h04);
		wr(8'h01, 8'h80);
		rd(8'h01, 8'h80);
		wr(8'h10, 8'h80);
		wr(8'h01, 8'h00);
		rd(8'h01, 8'h80);
		i_pofw_host.send(8'h12, 8'h00, 1'b0);
		rd(8'h01, 8'h80);
		wr(8'h10, 8'he0);
		wt;
		chk("cml", 8'h01, {7'h0, stat.cml});
		wr(8'h02, 8'h00);
		rd(8'h02, 8'h00);
		wr(8'h10, 8'h00);
		i_pofw_host.clear_twice;
		wt;
		chk("alert", 8'h00, {7'h0, stat.alert});
		flat = 1'b1;
		flt = 1'b1;
		wt;
		clr;
		chk("fault", 8'h01, {7'h0, stat.fault_flag});
		flt = 1'b0;
		clr;
		chk("fault", 8'h00, {7'h0, stat.fault_flag});
		chk("run", 8'h00, {7'h0, stat.run});
		ov = 1'b1;
		wt;
		ov = 1'b0;
		chk("switch", 8'h01, {7'h0, stat.ls_on});
		clr;
		chk("switch", 8'h00, {7'h0, stat.ls_on});
		chk("ovflag", 8'h01, {7'h0, stat.ov_flag});
		clr;
		chk("ovflag", 8'h00, {7'h0, stat.ov_flag});
		// power cycle with a stored active-low polarity
		flat = 1'b0;
		nvm_set = 8'h14;
		i_srst = 1'b1;
		repeat (2) @(negedge i_clk);
		i_srst = 1'b0;
		repeat (3) @(negedge i_clk);
		rd(8'h02, 8'h14);
		chk("run", 8'h01, {7'h0, stat.run});
		pin = 1'b1;
		wt;
		chk("run", 8'h00, {7'h0, stat.run});
		chk("hard", 8'h00, {7'h0, stat.hard_off});
		wr(8'h02, 8'h15);
		pin = 1'b0;
		wt;
		chk("run", 8'h01, {7'h0, stat.run});
		pin = 1'b1;
		wt;
		chk("hard", 8'h01, {7'h0, stat.hard_off});
		ovrs = 1'b1;
		flat = 1'b1;
		ov = 1'b1;
		wt;
		ov = 1'b0;
		chk("switch", 8'h01, {7'h0, stat.ls_on});
		buv = 1'b1;
		wt;
		chk("switch", 8'h00, {7'h0, stat.ls_on});
		complete_run;
	end
endmodule
bind pofw_ctrl pofw_sva i_pofw_sva(.i_clk, .i_srst, .i_cmd, .i_rd_code, .i_vin_ok, .i_fault,
	.o_rd_data, .o_store_req, .o_vout_we, .o_stat);
